/* include/led_reg_pkg.sv */
// Purpose: shared constants of the led driver register front end
// Assumes: byte events come from an i2c byte engine on the same clock
// Notes:   register indices are 5-bit pointer values
//
// Notes on behaviour
// - after an acknowledged write address the first written byte loads the command register
// - command bits 4..0 form the pointer selecting the accessed register
// - command bits 7..5 are increment enable plus two-bit range selector
// - with increment enabled the pointer advances after each data byte
// - selector zero keeps the pointer fixed; repeated writes overwrite one register
// - all-register range wraps from 1 0001 back to 0 0000
// - duty range cycles 0 0010 to 0 1001, then back to 0 0010
// - global range alternates 0 1010 and 0 1011
// - duty plus global range wraps from 0 1011 to 0 0010
// - stepping changes only the pointer field, never the selector bits
// - written pointer is the first register accessed, 0 0000 to 1 0001
// - mode one bits 7..5 are read-only copies of the selector, reset 0
// - mode one bit 4 is low-power (oscillator stop), reset 1
// - mode one bits 3..1 enable group addresses one to three, reset 0
// - mode one bit 0 enables the broadcast address, reset 1
// - broadcast address acknowledged from reset at 90h write, 91h read
package led_reg_pkg;

   localparam int unsigned DATA_W    = 8;
   localparam int unsigned PTR_W     = 5;
   localparam int unsigned SEL_W     = 3;
   localparam int unsigned REG_COUNT = 18;
   localparam int unsigned DUTY_CNT  = 8;

   // register indices
   localparam logic [4:0] REG_MODE_ONE     = 5'h00;
   localparam logic [4:0] REG_MODE_TWO     = 5'h01;
   localparam logic [4:0] REG_DUTY_FIRST   = 5'h02;
   localparam logic [4:0] REG_DUTY_LAST    = 5'h09;
   localparam logic [4:0] REG_GROUP_DUTY   = 5'h0A;
   localparam logic [4:0] REG_GROUP_FREQ   = 5'h0B;
   localparam logic [4:0] REG_STATE_LOW    = 5'h0C;
   localparam logic [4:0] REG_STATE_HIGH   = 5'h0D;
   localparam logic [4:0] REG_GRP_ADDR_ONE = 5'h0E;
   localparam logic [4:0] REG_GRP_ADDR_TWO = 5'h0F;
   localparam logic [4:0] REG_GRP_ADDR_THR = 5'h10;
   localparam logic [4:0] REG_BROADCAST    = 5'h11;
   localparam logic [4:0] REG_FIRST        = 5'h00;
   localparam logic [4:0] REG_LAST         = 5'h11;

   // increment selector codes
   localparam logic [2:0] SEL_NONE        = 3'h0;
   localparam logic [2:0] SEL_ALL         = 3'h4;
   localparam logic [2:0] SEL_DUTY        = 3'h5;
   localparam logic [2:0] SEL_GLOBAL      = 3'h6;
   localparam logic [2:0] SEL_DUTY_GLOBAL = 3'h7;

   // command byte fields
   localparam int unsigned CMD_SEL_MSB = 7;
   localparam int unsigned CMD_SEL_LSB = 5;
   localparam int unsigned CMD_PTR_MSB = 4;
   localparam int unsigned CMD_PTR_LSB = 0;

   // mode one bit positions
   localparam int unsigned M1_SLEEP_BIT = 4;
   localparam int unsigned M1_GRP1_BIT  = 3;
   localparam int unsigned M1_GRP2_BIT  = 2;
   localparam int unsigned M1_GRP3_BIT  = 1;
   localparam int unsigned M1_BCAST_BIT = 0;

   // writable bits; the rest read back as zero or selector copy
   localparam logic [7:0] MODE_ONE_WMASK = 8'h1F;
   localparam logic [7:0] MODE_TWO_WMASK = 8'h2F;

   // address byte: bit 0 is read/not-write
   localparam int unsigned ADDR_RW_BIT = 0;
   localparam logic [7:0]  READ_ZERO   = 8'h00;

   // reset image, index order
   localparam logic [7:0] RESET_VALUE [REG_COUNT] = '{
      8'h11, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h92, 8'h94,
      8'h98, 8'h90
   };

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_CMD,
      ST_WDATA,
      ST_RDATA
   } front_state_t;

endpackage

/* core/pointer_step.sv */
// Purpose: next pointer value for the register auto-increment
// Assumes: selector held steady for the transaction
// Notes:   purely combinational
`timescale 1ns/1ns
module pointer_step (
   input  wire logic [4:0] ptr,
   input  wire logic [2:0] sel,
   output logic      [4:0] nxt_ptr
);

   ////////////////////////////////////////////////////////////////////////
   // wrap inside the range picked by the selector
   always_comb begin
      nxt_ptr = ptr;
      unique case (sel)
         led_reg_pkg::SEL_ALL: begin
            if (ptr >= led_reg_pkg::REG_LAST) begin
               nxt_ptr = led_reg_pkg::REG_FIRST;
            end else begin
               nxt_ptr = ptr + 5'h01;
            end
         end
         led_reg_pkg::SEL_DUTY: begin
            if (ptr >= led_reg_pkg::REG_DUTY_LAST) begin
               nxt_ptr = led_reg_pkg::REG_DUTY_FIRST;
            end else begin
               nxt_ptr = ptr + 5'h01;
            end
         end
         led_reg_pkg::SEL_GLOBAL: begin
            if (ptr >= led_reg_pkg::REG_GROUP_FREQ) begin
               nxt_ptr = led_reg_pkg::REG_GROUP_DUTY;
            end else begin
               nxt_ptr = ptr + 5'h01;
            end
         end
         led_reg_pkg::SEL_DUTY_GLOBAL: begin
            if (ptr >= led_reg_pkg::REG_GROUP_FREQ) begin
               nxt_ptr = led_reg_pkg::REG_DUTY_FIRST;
            end else begin
               nxt_ptr = ptr + 5'h01;
            end
         end
         default: begin
            nxt_ptr = ptr;
         end
      endcase
   end

endmodule

/* core/led_reg_bank.sv */
// Purpose: command register, pointer stepping and register map of the
//          eight-channel led driver
// Assumes: byte engine delivers one-cycle strobes on the same clock
// Notes:   address match for own, broadcast and group addresses lives here
`timescale 1ns/1ns
module led_reg_bank (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic [6:0]  own_address,
   input  wire logic        start_seen,
   input  wire logic        stop_seen,
   input  wire logic        addr_valid,
   input  wire logic [7:0]  addr_byte,
   input  wire logic        wr_valid,
   input  wire logic [7:0]  wr_data,
   input  wire logic        rd_req,
   output logic             addr_done,
   output logic             addr_ack,
   output logic             rd_valid,
   output logic      [7:0]  rd_data,
   output logic      [4:0]  reg_pointer,
   output logic      [2:0]  increment_selector,
   output logic             sleep_mode,
   output logic             group_addr_one_enable,
   output logic             group_addr_two_enable,
   output logic             group_addr_three_enable,
   output logic             broadcast_enable,
   output logic      [7:0]  mode_control_two,
   output logic      [63:0] duty_outputs,
   output logic      [7:0]  group_duty,
   output logic      [7:0]  group_frequency,
   output logic      [7:0]  output_state_low,
   output logic      [7:0]  output_state_high
);

   ////////////////////////////////////////////////////////////////////////
   // declarations

   logic                      rst_meta_ff;
   logic                      rst_sync_ff;
   logic                      rst_n;

   led_reg_pkg::front_state_t state_ff;
   led_reg_pkg::front_state_t nxt_state;

   logic [4:0]                ptr_ff;
   logic [2:0]                sel_ff;
   logic [4:0]                step_ptr;

   logic [7:0]                regs_ff [led_reg_pkg::REG_COUNT];

   logic                      addr_done_ff;
   logic                      addr_ack_ff;
   logic                      rd_valid_ff;
   logic [7:0]                rd_data_ff;

   logic                      match_own;
   logic                      match_bcast;
   logic                      match_grp1;
   logic                      match_grp2;
   logic                      match_grp3;
   logic                      addr_hit;

   logic                      cmd_take;
   logic                      data_take;
   logic                      read_take;
   logic                      ptr_in_map;
   logic [7:0]                read_value;
   logic [7:0]                mode_one_view;

   ////////////////////////////////////////////////////////////////////////
   // reset release through two flops

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end

   assign rst_n = rst_sync_ff;

   ////////////////////////////////////////////////////////////////////////
   // address recognition

   // own address always answers
   assign match_own = (addr_byte[7:1] == own_address);

   // broadcast compare against the programmable address
   assign match_bcast =
      regs_ff[led_reg_pkg::REG_MODE_ONE][led_reg_pkg::M1_BCAST_BIT] &&
      (addr_byte[7:1] == regs_ff[led_reg_pkg::REG_BROADCAST][7:1]);

   // group addresses, each behind its own enable
   assign match_grp1 =
      regs_ff[led_reg_pkg::REG_MODE_ONE][led_reg_pkg::M1_GRP1_BIT] &&
      (addr_byte[7:1] == regs_ff[led_reg_pkg::REG_GRP_ADDR_ONE][7:1]);
   assign match_grp2 =
      regs_ff[led_reg_pkg::REG_MODE_ONE][led_reg_pkg::M1_GRP2_BIT] &&
      (addr_byte[7:1] == regs_ff[led_reg_pkg::REG_GRP_ADDR_TWO][7:1]);
   assign match_grp3 =
      regs_ff[led_reg_pkg::REG_MODE_ONE][led_reg_pkg::M1_GRP3_BIT] &&
      (addr_byte[7:1] == regs_ff[led_reg_pkg::REG_GRP_ADDR_THR][7:1]);

   assign addr_hit = match_own || match_bcast || match_grp1 ||
                     match_grp2 || match_grp3;

   ////////////////////////////////////////////////////////////////////////
   // transaction sequencing

   // what the current strobe means in the current state
   assign cmd_take  = wr_valid && (state_ff == led_reg_pkg::ST_CMD);
   assign data_take = wr_valid && (state_ff == led_reg_pkg::ST_WDATA);
   assign read_take = rd_req && (state_ff == led_reg_pkg::ST_RDATA);

   // next state from address, data and bus conditions
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         led_reg_pkg::ST_IDLE: begin
            nxt_state = led_reg_pkg::ST_IDLE;
         end
         led_reg_pkg::ST_CMD: begin
            if (wr_valid) begin
               nxt_state = led_reg_pkg::ST_WDATA;
            end
         end
         led_reg_pkg::ST_WDATA: begin
            nxt_state = led_reg_pkg::ST_WDATA;
         end
         led_reg_pkg::ST_RDATA: begin
            nxt_state = led_reg_pkg::ST_RDATA;
         end
      endcase
      if (addr_valid) begin
         if (!addr_hit) begin
            nxt_state = led_reg_pkg::ST_IDLE;
         end else if (addr_byte[led_reg_pkg::ADDR_RW_BIT]) begin
            nxt_state = led_reg_pkg::ST_RDATA;
         end else begin
            nxt_state = led_reg_pkg::ST_CMD;
         end
      end
      if (start_seen || stop_seen) begin
         nxt_state = led_reg_pkg::ST_IDLE;
      end
   end

   // state register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= led_reg_pkg::ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // address answer, one cycle after the address strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_done_ff <= 1'b0;
         addr_ack_ff  <= 1'b0;
      end else begin
         addr_done_ff <= addr_valid;
         addr_ack_ff  <= addr_valid && addr_hit;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // command register: pointer and selector

   pointer_step u_step (
      .ptr     (ptr_ff),
      .sel     (sel_ff),
      .nxt_ptr (step_ptr)
   );

   // pointer loads from the command byte, then steps per data byte
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ptr_ff <= led_reg_pkg::REG_FIRST;
      end else if (cmd_take) begin
         ptr_ff <= wr_data[led_reg_pkg::CMD_PTR_MSB:
                           led_reg_pkg::CMD_PTR_LSB];
      end else if (data_take || read_take) begin
         ptr_ff <= step_ptr;
      end
   end

   // selector changes only on a command byte
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_ff <= led_reg_pkg::SEL_NONE;
      end else if (cmd_take) begin
         sel_ff <= wr_data[led_reg_pkg::CMD_SEL_MSB:
                           led_reg_pkg::CMD_SEL_LSB];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register map

   assign ptr_in_map = (ptr_ff <= led_reg_pkg::REG_LAST);

   // one storage slot per register, written only when pointed at
   for (genvar idx = 0; idx < led_reg_pkg::REG_COUNT; idx++) begin : g_reg
      localparam logic [4:0] IDX = 5'(idx);
      logic [7:0] wmask;
      assign wmask = (IDX == led_reg_pkg::REG_MODE_ONE) ?
                        led_reg_pkg::MODE_ONE_WMASK :
                     (IDX == led_reg_pkg::REG_MODE_TWO) ?
                        led_reg_pkg::MODE_TWO_WMASK : 8'hFF;
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            regs_ff[idx] <= led_reg_pkg::RESET_VALUE[idx];
         end else if (data_take && ptr_in_map && (ptr_ff == IDX)) begin
            regs_ff[idx] <= (wr_data & wmask) |
                            (regs_ff[idx] & ~wmask);
         end
      end
   end

   // mode one shows the live selector in its top bits
   assign mode_one_view =
      {sel_ff,
       regs_ff[led_reg_pkg::REG_MODE_ONE][led_reg_pkg::M1_SLEEP_BIT:0]};

   // read mux; holes beyond the map read zero
   always_comb begin
      read_value = led_reg_pkg::READ_ZERO;
      if (!ptr_in_map) begin
         read_value = led_reg_pkg::READ_ZERO;
      end else if (ptr_ff == led_reg_pkg::REG_MODE_ONE) begin
         read_value = mode_one_view;
      end else begin
         read_value = regs_ff[ptr_ff];
      end
   end

   // read answer one cycle after the request
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_valid_ff <= 1'b0;
         rd_data_ff  <= led_reg_pkg::READ_ZERO;
      end else begin
         rd_valid_ff <= read_take;
         if (read_take) begin
            rd_data_ff <= read_value;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs, all straight from flops

   assign addr_done          = addr_done_ff;
   assign addr_ack           = addr_ack_ff;
   assign rd_valid           = rd_valid_ff;
   assign rd_data            = rd_data_ff;
   assign reg_pointer        = ptr_ff;
   assign increment_selector = sel_ff;

   // mode one controls
   assign sleep_mode =
      regs_ff[led_reg_pkg::REG_MODE_ONE][led_reg_pkg::M1_SLEEP_BIT];
   assign group_addr_one_enable =
      regs_ff[led_reg_pkg::REG_MODE_ONE][led_reg_pkg::M1_GRP1_BIT];
   assign group_addr_two_enable =
      regs_ff[led_reg_pkg::REG_MODE_ONE][led_reg_pkg::M1_GRP2_BIT];
   assign group_addr_three_enable =
      regs_ff[led_reg_pkg::REG_MODE_ONE][led_reg_pkg::M1_GRP3_BIT];
   assign broadcast_enable =
      regs_ff[led_reg_pkg::REG_MODE_ONE][led_reg_pkg::M1_BCAST_BIT];

   // settings for the pwm and output stages
   assign mode_control_two  = regs_ff[led_reg_pkg::REG_MODE_TWO];
   assign group_duty        = regs_ff[led_reg_pkg::REG_GROUP_DUTY];
   assign group_frequency   = regs_ff[led_reg_pkg::REG_GROUP_FREQ];
   assign output_state_low  = regs_ff[led_reg_pkg::REG_STATE_LOW];
   assign output_state_high = regs_ff[led_reg_pkg::REG_STATE_HIGH];

   // eight duty bytes packed channel 0 in the low byte
   for (genvar ch = 0; ch < led_reg_pkg::DUTY_CNT; ch++) begin : g_duty
      assign duty_outputs[ch*8 +: 8] =
         regs_ff[int'(led_reg_pkg::REG_DUTY_FIRST) + ch];
   end

endmodule

/* bench/led_reg_bank_sva.sv */
// Purpose: port assertions for the led register front end
// Assumes: strobes are one-cycle pulses on clk
// Notes:   bound to every led_reg_bank instance
`timescale 1ns/1ns
module led_reg_bank_sva (
   input wire logic       clk,
   input wire logic       resetn,
   input wire logic       addr_valid,
   input wire logic       wr_valid,
   input wire logic       rd_req,
   input wire logic       addr_done,
   input wire logic       addr_ack,
   input wire logic       rd_valid,
   input wire logic [4:0] reg_pointer,
   input wire logic [2:0] increment_selector,
   input wire logic       sleep_mode,
   input wire logic       broadcast_enable
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   // wrap check: read under selector s at pointer f lands on t
   property p_wrap(logic [2:0] s, logic [4:0] f, logic [4:0] t);
      rd_valid && $past(increment_selector) == s && $past(reg_pointer) == f
         |-> reg_pointer == t;
   endproperty
   ////////////////////////////////////////
   property p_addr_done;
      addr_valid |=> addr_done;
   endproperty
   property p_done_cause;
      addr_done |-> $past(addr_valid);
   endproperty
   property p_ack_in_done;
      addr_ack |-> addr_done;
   endproperty
   property p_ptr_hold;
      !$past(wr_valid) && !$past(rd_req) |-> $stable(reg_pointer);
   endproperty
   property p_rd_step;
      rd_valid && $past(increment_selector[2])
         |-> reg_pointer != $past(reg_pointer);
   endproperty
   property p_fixed;
      rd_valid && $past(increment_selector) == led_reg_pkg::SEL_NONE
         |-> $stable(reg_pointer);
   endproperty
   property p_sel_hold;
      !$past(wr_valid) |-> $stable(increment_selector);
   endproperty
   property p_mode_hold;
      !$past(wr_valid) |-> $stable(sleep_mode) && $stable(broadcast_enable);
   endproperty
   property p_wrap_all;
      p_wrap(led_reg_pkg::SEL_ALL, 5'h11, 5'h00);
   endproperty
   property p_wrap_duty;
      p_wrap(led_reg_pkg::SEL_DUTY, 5'h09, 5'h02);
   endproperty
   property p_wrap_glob;
      p_wrap(led_reg_pkg::SEL_GLOBAL, 5'h0B, 5'h0A);
   endproperty
   property p_wrap_dg;
      p_wrap(led_reg_pkg::SEL_DUTY_GLOBAL, 5'h0B, 5'h02);
   endproperty
   ////////////////////////////////////////
   a_addr_done: assert property (p_addr_done)
      else $error("address strobe got no done pulse");
   a_done_cause: assert property (p_done_cause)
      else $error("done pulse without address strobe");
   a_ack_in_done: assert property (p_ack_in_done)
      else $error("ack outside done pulse");
   a_ptr_hold: assert property (p_ptr_hold)
      else $error("pointer moved without a byte");
   a_rd_step: assert property (p_rd_step)
      else $error("pointer did not step after read");
   a_fixed: assert property (p_fixed)
      else $error("pointer moved with selector zero");
   a_sel_hold: assert property (p_sel_hold)
      else $error("selector changed without a write");
   a_mode_hold: assert property (p_mode_hold)
      else $error("mode bits changed without a write");
   a_wrap_all: assert property (p_wrap_all)
      else $error("all range wrap wrong");
   a_wrap_duty: assert property (p_wrap_duty)
      else $error("duty range wrap wrong");
   a_wrap_glob: assert property (p_wrap_glob)
      else $error("global range wrap wrong");
   a_wrap_dg: assert property (p_wrap_dg)
      else $error("duty global range wrap wrong");
   c_ack: cover property (addr_ack);
   c_rd: cover property (rd_valid);
   c_wrap: cover property (rd_valid && $past(reg_pointer) == 5'h11 &&
                           reg_pointer == 5'h00);
endmodule

bind led_reg_bank led_reg_bank_sva u_led_reg_bank_sva (
   .clk(clk), .resetn(resetn), .addr_valid(addr_valid),
   .wr_valid(wr_valid), .rd_req(rd_req), .addr_done(addr_done),
   .addr_ack(addr_ack), .rd_valid(rd_valid), .reg_pointer(reg_pointer),
   .increment_selector(increment_selector), .sleep_mode(sleep_mode),
   .broadcast_enable(broadcast_enable)
);

/* bench/bus_master_model.sv */
// Purpose: byte-level model of the bus master feeding the front end
// Assumes: strobes change on the falling edge of clk
// Notes:   gap adds idle cycles before each request for a slow master
`timescale 1ns/1ns
module bus_master_model (
   input  wire logic       clk,
   input  wire logic       addr_done,
   input  wire logic       addr_ack,
   input  wire logic       rd_valid,
   input  wire logic [7:0] rd_data,
   output logic            start_seen,
   output logic            stop_seen,
   output logic            addr_valid,
   output logic      [7:0] addr_byte,
   output logic            wr_valid,
   output logic      [7:0] wr_data,
   output logic            rd_req
);
   int gap = 0;

   // idle bus at time zero
   initial begin
      {start_seen, stop_seen, addr_valid, wr_valid, rd_req} = 5'h00;
      addr_byte = 8'h00;
      wr_data   = 8'h00;
   end
   ////////////////////////////////////////
   // start, then address byte; ack sampled with the done pulse
   task automatic addr(input logic [7:0] a, output logic ack);
      repeat (gap) @(negedge clk);
      @(negedge clk);
      start_seen = 1'b1;
      @(negedge clk);
      start_seen = 1'b0;
      addr_valid = 1'b1;
      addr_byte  = a;
      @(negedge clk);
      addr_valid = 1'b0;
      addr_byte  = ~a; // released lane shows no stale value
      ack = addr_ack & addr_done;
   endtask
   task automatic send(input logic [7:0] d);
      repeat (gap) @(negedge clk);
      @(negedge clk);
      wr_valid = 1'b1;
      wr_data  = d;
      @(negedge clk);
      wr_valid = 1'b0;
      wr_data  = ~d;
   endtask
   // command byte right after the address, reserved selector codes sent as zero
   task automatic cmd(input logic [7:0] c);
      if (c[7:5] inside {3'h1, 3'h2, 3'h3}) c[7:5] = 3'h0;
      send(c);
   endtask
   task automatic rd(output logic [7:0] d, output logic v);
      repeat (gap) @(negedge clk);
      @(negedge clk);
      rd_req = 1'b1;
      @(negedge clk);
      rd_req = 1'b0;
      v = rd_valid;
      d = rd_data;
   endtask
   task automatic stop();
      @(negedge clk);
      stop_seen = 1'b1;
      @(negedge clk);
      stop_seen = 1'b0;
   endtask
endmodule

/* bench/testbench.sv */
// Purpose: directed checks of pointer stepping and register map
// Assumes: own address 20h, so 40h writes and 41h reads
// Notes:   expected values come from the register table
`timescale 1ns/1ns
`define CHK(nm, e, g) begin compares++; \
   if ((g) !== (e)) begin num_errors++; \
   $display("mismatch %s exp %h got %h", nm, e, g); end end
module testbench;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic        ack;
   logic        start_seen, stop_seen, addr_valid, wr_valid, rd_req;
   logic [7:0]  addr_byte, wr_data, rd_data, mode_control_two;
   logic        addr_done, addr_ack, rd_valid, sleep_mode;
   logic        g1, g2, g3, broadcast_enable;
   logic [4:0]  reg_pointer;
   logic [2:0]  increment_selector;
   logic [63:0] duty;
   logic [7:0]  group_duty, group_frequency, st_low, st_high;
   int          num_errors = 0;
   int          compares = 0;
   int          cycles = 0;

   always #5 clk = ~clk;

   led_reg_bank u_led_reg_bank (
      .clk(clk), .resetn(resetn), .own_address(7'h20),
      .start_seen(start_seen), .stop_seen(stop_seen),
      .addr_valid(addr_valid), .addr_byte(addr_byte),
      .wr_valid(wr_valid), .wr_data(wr_data), .rd_req(rd_req),
      .addr_done(addr_done), .addr_ack(addr_ack), .rd_valid(rd_valid),
      .rd_data(rd_data), .reg_pointer(reg_pointer),
      .increment_selector(increment_selector), .sleep_mode(sleep_mode),
      .group_addr_one_enable(g1), .group_addr_two_enable(g2),
      .group_addr_three_enable(g3), .broadcast_enable(broadcast_enable),
      .mode_control_two(mode_control_two), .duty_outputs(duty),
      .group_duty(group_duty), .group_frequency(group_frequency),
      .output_state_low(st_low), .output_state_high(st_high));

   bus_master_model u_bus_master_model (
      .clk(clk), .addr_done(addr_done), .addr_ack(addr_ack),
      .rd_valid(rd_valid), .rd_data(rd_data), .start_seen(start_seen),
      .stop_seen(stop_seen), .addr_valid(addr_valid),
      .addr_byte(addr_byte), .wr_valid(wr_valid), .wr_data(wr_data),
      .rd_req(rd_req));
   ////////////////////////////////////////
   task final_report;
      if (num_errors == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles > 5000) begin
         num_errors++;
         final_report;
      end
   end

   // write: command then n data bytes, lowest byte first
   task wseq(input logic [7:0] c, input logic [23:0] d, input int n);
      logic a;
      u_bus_master_model.addr(8'h40, a);
      `CHK("wr ack", 1'b1, a)
      u_bus_master_model.cmd(c);
      for (int i = 0; i < n; i++) u_bus_master_model.send(d[8*i+:8]);
      u_bus_master_model.stop();
   endtask
   // read two bytes after a repeated start, first byte in e[7:0]
   task rseq(input logic [7:0] c, input logic [15:0] e);
      logic       a;
      logic       v;
      logic [7:0] d;
      u_bus_master_model.addr(8'h40, a);
      u_bus_master_model.cmd(c);
      u_bus_master_model.addr(8'h41, a);
      `CHK("rd ack", 1'b1, a)
      for (int i = 0; i < 2; i++) begin
         u_bus_master_model.rd(d, v);
         `CHK("rd valid", 1'b1, v)
         `CHK("rd data", e[8*i+:8], d)
      end
      u_bus_master_model.stop();
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (12) @(negedge clk);
      resetn = 1'b1;
      repeat (4) @(negedge clk);
      `CHK("sleep", 1'b1, sleep_mode)
      `CHK("bcast en", 1'b1, broadcast_enable)
      `CHK("grp en", 3'h0, {g1, g2, g3})
      `CHK("selector", 3'h0, increment_selector)
      `CHK("mode two", 8'h03, mode_control_two)
      `CHK("grp duty", 8'hFF, group_duty)
      `CHK("grp freq", 8'h00, group_frequency)
      u_bus_master_model.addr(8'h90, ack);
      `CHK("ack 90", 1'b1, ack)
      u_bus_master_model.addr(8'h91, ack);
      `CHK("ack 91", 1'b1, ack)
      u_bus_master_model.addr(8'h92, ack);
      `CHK("ack 92", 1'b0, ack)
      u_bus_master_model.stop();
      // all-range writes across the wrap into mode one
      wseq(8'h90, 24'h0F9098, 3);
      `CHK("ptr all", 5'h01, reg_pointer)
      `CHK("selector", 3'h4, increment_selector)
      `CHK("sleep", 1'b0, sleep_mode)
      `CHK("grp en", 3'h7, {g1, g2, g3})
      u_bus_master_model.addr(8'h98, ack);
      `CHK("ack 98", 1'b1, ack)
      u_bus_master_model.stop();
      wseq(8'hA9, 24'h002211, 2);
      `CHK("duty7", 8'h11, duty[63:56])
      `CHK("ptr duty", 5'h03, reg_pointer)
      wseq(8'hCB, 24'h004433, 2);
      `CHK("grp duty", 8'h44, group_duty)
      `CHK("ptr glob", 5'h0B, reg_pointer)
      wseq(8'hEB, 24'h006655, 2);
      `CHK("duty0", 8'h66, duty[7:0])
      `CHK("ptr dg", 5'h03, reg_pointer)
      wseq(8'h0C, 24'h008877, 2);
      `CHK("st low", 8'h88, st_low)
      `CHK("st high", 8'h00, st_high)
      wseq(8'h14, 24'h0000AA, 1);
      `CHK("mode two", 8'h03, mode_control_two)
      `CHK("grp freq", 8'h55, group_frequency)
      // upper mode one bits refuse writes
      wseq(8'h00, 24'h0000E0, 1);
      `CHK("selector", 3'h0, increment_selector)
      `CHK("bcast en", 1'b0, broadcast_enable)
      u_bus_master_model.addr(8'h90, ack);
      `CHK("ack 90 off", 1'b0, ack)
      u_bus_master_model.stop();
      // reads, first one through a slow master
      u_bus_master_model.gap = 3;
      rseq(8'h91, 16'h8090);
      u_bus_master_model.gap = 0;
      rseq(8'hA9, 16'h6611);
      rseq(8'hCB, 16'h4455);
      rseq(8'hEB, 16'h6655);
      `CHK("selector", 3'h7, increment_selector)
      rseq(8'h0C, 16'h8888);
      rseq(8'h14, 16'h0000);
      // foreign address: following bytes ignored
      u_bus_master_model.addr(8'h30, ack);
      `CHK("ack 30", 1'b0, ack)
      u_bus_master_model.send(8'h0D);
      u_bus_master_model.send(8'h5A);
      u_bus_master_model.stop();
      `CHK("ptr kept", 5'h14, reg_pointer)
      `CHK("st high", 8'h00, st_high)
      final_report;
   end
endmodule
